// *** optcfg_pkg.sv ***
// shared constants for the configuration byte decoder
package optcfg_pkg;

  // register map
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_BYTE0  = 8'h08;
  localparam logic [7:0] OFS_BYTE1  = 8'h0c;
  localparam logic [7:0] OFS_DECODE = 8'h10;

  // field positions, byte 0
  localparam int B0_WDOG_HALT = 7;
  localparam int B0_WDOG_TYPE = 6;
  localparam int B0_RSV_HI    = 5;
  localparam int B0_VD_HI     = 4;
  localparam int B0_VD_LO     = 3;
  localparam int B0_RSV_LO    = 2;
  localparam int B0_PKG_LO    = 1;
  localparam int B0_PROTECT   = 0;
  // field positions, byte 1
  localparam int B1_PKG_HI    = 7;
  localparam int B1_RST_LEN   = 6;
  localparam int B1_OSC_HI    = 5;
  localparam int B1_OSC_LO    = 4;
  localparam int B1_RANGE_HI  = 3;
  localparam int B1_RANGE_LO  = 1;
  localparam int B1_DOUBLER   = 0;

  // values
  localparam logic [7:0] ERASED_BYTE   = 8'hff;
  localparam logic [7:0] BLANK_BYTE0   = 8'hff;
  localparam logic [7:0] BLANK_BYTE1   = 8'hef;
  localparam logic [1:0] VD_OFF        = 2'h3;
  localparam logic [1:0] VD_LOWEST     = 2'h2;
  localparam logic [1:0] VD_MEDIUM     = 2'h1;
  localparam logic [1:0] VD_HIGHEST    = 2'h0;
  localparam logic [1:0] OSC_RESONATOR = 2'h0;
  localparam logic [1:0] OSC_RESERVED  = 2'h1;
  localparam logic [1:0] OSC_INT_RC    = 2'h2;
  localparam logic [1:0] OSC_EXTERNAL  = 2'h3;
  localparam logic [1:0] PKG_64        = 2'h2;
  localparam logic [1:0] PKG_44        = 2'h0;
  localparam logic [12:0] RST_CYC_LONG  = 13'h1000;
  localparam logic [12:0] RST_CYC_SHORT = 13'h0100;
  localparam logic [7:0] CTRL_RST      = 8'h00;
  localparam int ERASE_CYCLES_DEF      = 64;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_MEM_ERASE,
    ST_OPT_ERASE
  } erase_state_t;

endpackage

// *** optcfg_decode.sv ***
// combinational decode of the two configuration bytes
`timescale 1ns/1ps
module optcfg_decode
  import optcfg_pkg::*;
(
  input  wire logic [7:0]  byte0,
  input  wire logic [7:0]  byte1,
  input  wire logic        maskCoded,
  output logic             wdogHaltResetSel,
  output logic             wdogHwAlways,
  output logic             lowSupplyDetectorEn,
  output logic             auxSupplyDetectorEn,
  output logic [1:0]       voltThreshold,
  output logic             readoutProtect,
  output logic             package64,
  output logic             packageValid,
  output logic [12:0]      resetCycles,
  output logic [1:0]       oscKindSel,
  output logic             oscKindReserved,
  output logic [2:0]       oscFreqRange,
  output logic             resonatorDriveSel,
  output logic             doublerEnable
);

  logic [1:0] voltDetectSel;
  logic [1:0] pkgSel;

  always_comb begin
    wdogHaltResetSel = byte0[B0_WDOG_HALT];
    wdogHwAlways     = ~byte0[B0_WDOG_TYPE];
    voltDetectSel    = byte0[B0_VD_HI:B0_VD_LO];
    lowSupplyDetectorEn = (voltDetectSel != VD_OFF);
    auxSupplyDetectorEn = (voltDetectSel != VD_OFF);
    voltThreshold    = voltDetectSel;
    // programmable parts store protection inverted
    readoutProtect   = maskCoded ? byte0[B0_PROTECT] : ~byte0[B0_PROTECT];
    pkgSel           = {byte1[B1_PKG_HI], byte0[B0_PKG_LO]};
    package64        = (pkgSel == PKG_64);
    packageValid     = (pkgSel == PKG_64) || (pkgSel == PKG_44);
    resetCycles      = byte1[B1_RST_LEN] ? RST_CYC_SHORT : RST_CYC_LONG;
    oscKindSel       = byte1[B1_OSC_HI:B1_OSC_LO];
    oscKindReserved  = (oscKindSel == OSC_RESERVED);
    oscFreqRange     = byte1[B1_RANGE_HI:B1_RANGE_LO];
    resonatorDriveSel = (oscKindSel == OSC_RESONATOR);
    doublerEnable    = ~byte1[B1_DOUBLER];
  end

endmodule

// *** option_byte_config_decoder.sv ***
// configuration byte store, programming access and decoded settings
`timescale 1ns/1ps
module option_byte_config_decoder
  import optcfg_pkg::*;
#(
  parameter int         ERASE_CYCLES = ERASE_CYCLES_DEF,
  parameter logic [7:0] MASK_BYTE0   = BLANK_BYTE0,
  parameter logic [7:0] MASK_BYTE1   = BLANK_BYTE1
)(
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        clkEn,
  input  wire logic        maskCodedPin,
  input  wire logic        progModePin,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  output logic             userMemErase,
  output logic             padPullupForce,
  output logic             wdogHaltResetSel,
  output logic             wdogHwAlways,
  output logic             lowSupplyDetectorEn,
  output logic             auxSupplyDetectorEn,
  output logic [1:0]       voltThreshold,
  output logic             readoutProtect,
  output logic             package64,
  output logic [12:0]      resetCycles,
  output logic [1:0]       oscKindSel,
  output logic [2:0]       oscFreqRange,
  output logic             resonatorDriveSel,
  output logic             doublerEnable
);

  logic        rstSync1;
  logic        rstSync2;
  logic        rstN;
  logic [1:0]  progSync;
  logic [1:0]  maskSync;
  logic        progMode;
  logic        maskCoded;
  logic [7:0]  byte0_reg;
  logic [7:0]  byte1_reg;
  logic [7:0]  ctrl_reg;
  logic        latched_reg;
  logic [1:0]  settle_reg;
  logic        ack_reg;
  logic        err_reg;
  logic [31:0] rdata_reg;
  erase_state_t erase_reg;
  logic [15:0] eraseCnt_reg;
  logic [7:0]  src0;
  logic [7:0]  src1;
  logic        decHalt;
  logic        decHw;
  logic        decLvd;
  logic        decAvd;
  logic [1:0]  decThr;
  logic        decProt;
  logic        dec64;
  logic        decPkgOk;
  logic [12:0] decRst;
  logic [1:0]  decOsc;
  logic        decOscRsv;
  logic [2:0]  decRange;
  logic        decResDrv;
  logic        decDbl;
  logic        req;
  logic        wrByte0;
  logic        wrByte1;
  logic        eraseCmd;
  logic        busy;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr == ofs);
  endfunction

  // reset release
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rstSync1 <= 1'b0;
      rstSync2 <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstSync2 <= rstSync1;
    end
  end
  assign rstN = rstSync2;

  // pin synchronisers
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      progSync <= 2'h0;
      maskSync <= 2'h0;
    end else if (clkEn) begin
      progSync <= {progSync[0], progModePin};
      maskSync <= {maskSync[0], maskCodedPin};
    end
  end
  assign progMode  = progSync[1];
  assign maskCoded = maskSync[1];

  // strap settle: two enabled shifts before the strap copy is trusted
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      settle_reg <= 2'h0;
    end else if (clkEn && settle_reg != 2'h2) begin
      settle_reg <= settle_reg + 2'h1;
    end
  end

  assign busy = (erase_reg != ST_IDLE);
  // bus writes only in programming mode
  assign req      = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;
  assign wrByte0  = req && wb_we_i && progMode && !maskCoded && !busy
                    && wb_sel_i[0] && hit(wb_adr_i, OFS_BYTE0);
  assign wrByte1  = req && wb_we_i && progMode && !maskCoded && !busy
                    && wb_sel_i[0] && hit(wb_adr_i, OFS_BYTE1);
  assign eraseCmd = req && wb_we_i && progMode && !maskCoded && !busy
                    && wb_sel_i[0] && hit(wb_adr_i, OFS_CTRL) && wb_dat_i[0];

  // bus answer
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
    end else if (clkEn) begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      if (req) begin
        if (hit(wb_adr_i, OFS_CTRL) || hit(wb_adr_i, OFS_STATUS)
            || hit(wb_adr_i, OFS_BYTE0) || hit(wb_adr_i, OFS_BYTE1)
            || hit(wb_adr_i, OFS_DECODE)) begin
          ack_reg <= 1'b1;
        end else begin
          err_reg <= 1'b1;
        end
      end
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_err_o = err_reg;

  // read data
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      rdata_reg <= 32'h0;
    end else if (clkEn && req) begin
      rdata_reg <= 32'h0;
      if (hit(wb_adr_i, OFS_CTRL)) begin
        rdata_reg <= {24'h0, ctrl_reg};
      end else if (hit(wb_adr_i, OFS_STATUS)) begin
        rdata_reg <= {27'h0, progMode, maskCoded, decPkgOk, decOscRsv, busy};
      end else if (hit(wb_adr_i, OFS_BYTE0) && progMode) begin
        rdata_reg <= {24'h0, src0};
      end else if (hit(wb_adr_i, OFS_BYTE1) && progMode) begin
        rdata_reg <= {24'h0, src1};
      end else if (hit(wb_adr_i, OFS_DECODE)) begin
        rdata_reg <= {12'h0, readoutProtect, package64, doublerEnable, resonatorDriveSel,
                      oscFreqRange, oscKindSel, resetCycles[12:8], voltThreshold,
                      auxSupplyDetectorEn, lowSupplyDetectorEn, wdogHwAlways, wdogHaltResetSel};
      end
    end
  end
  assign wb_dat_o = rdata_reg;

  // control register: bit 0 reads back busy; a write with bit 0 set starts the erase
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      ctrl_reg <= CTRL_RST;
    end else if (clkEn) begin
      ctrl_reg <= {7'h0, busy};
    end
  end

  // erase sequence: user memory first when protected
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      erase_reg    <= ST_IDLE;
      eraseCnt_reg <= 16'h0;
    end else if (clkEn) begin
      case (erase_reg)
        ST_IDLE: begin
          if (eraseCmd) begin
            eraseCnt_reg <= 16'h0;
            erase_reg    <= (byte0_reg[B0_PROTECT] == 1'b0) ? ST_MEM_ERASE : ST_OPT_ERASE;
          end
        end
        ST_MEM_ERASE: begin
          if (eraseCnt_reg == 16'(ERASE_CYCLES - 1)) begin
            erase_reg <= ST_OPT_ERASE;
          end else begin
            eraseCnt_reg <= eraseCnt_reg + 16'h1;
          end
        end
        ST_OPT_ERASE: begin
          erase_reg <= ST_IDLE;
        end
        default: begin
          erase_reg <= ST_IDLE;
        end
      endcase
    end
  end
  assign userMemErase = (erase_reg == ST_MEM_ERASE);

  // programmable cells; blank content selects internal RC
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      byte0_reg <= BLANK_BYTE0;
      byte1_reg <= BLANK_BYTE1;
    end else if (clkEn) begin
      if (erase_reg == ST_OPT_ERASE) begin
        byte0_reg <= ERASED_BYTE;
        byte1_reg <= ERASED_BYTE;
      end else begin
        if (wrByte0) begin
          byte0_reg <= wb_dat_i[7:0];
        end
        if (wrByte1) begin
          byte1_reg <= wb_dat_i[7:0];
        end
      end
    end
  end

  assign src0 = maskCoded ? MASK_BYTE0 : byte0_reg;
  assign src1 = maskCoded ? MASK_BYTE1 : byte1_reg;

  optcfg_decode u_decode (
    .byte0               (src0),
    .byte1               (src1),
    .maskCoded           (maskCoded),
    .wdogHaltResetSel    (decHalt),
    .wdogHwAlways        (decHw),
    .lowSupplyDetectorEn (decLvd),
    .auxSupplyDetectorEn (decAvd),
    .voltThreshold       (decThr),
    .readoutProtect      (decProt),
    .package64           (dec64),
    .packageValid        (decPkgOk),
    .resetCycles         (decRst),
    .oscKindSel          (decOsc),
    .oscKindReserved     (decOscRsv),
    .oscFreqRange        (decRange),
    .resonatorDriveSel   (decResDrv),
    .doublerEnable       (decDbl)
  );

  // settings captured once after reset release, held until next reset
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      latched_reg         <= 1'b0;
      wdogHaltResetSel    <= 1'b1;
      wdogHwAlways        <= 1'b0;
      lowSupplyDetectorEn <= 1'b0;
      auxSupplyDetectorEn <= 1'b0;
      voltThreshold       <= VD_OFF;
      readoutProtect      <= 1'b0;
      package64           <= 1'b1;
      resetCycles         <= RST_CYC_LONG;
      oscKindSel          <= OSC_INT_RC;
      oscFreqRange        <= 3'h7;
      resonatorDriveSel   <= 1'b0;
      doublerEnable       <= 1'b0;
    end else if (clkEn && !latched_reg && settle_reg == 2'h2) begin
      latched_reg         <= 1'b1;
      wdogHaltResetSel    <= decHalt;
      wdogHwAlways        <= decHw;
      lowSupplyDetectorEn <= decLvd;
      auxSupplyDetectorEn <= decAvd;
      voltThreshold       <= decThr;
      readoutProtect      <= decProt;
      package64           <= dec64;
      resetCycles         <= decRst;
      oscKindSel          <= decOsc;
      oscFreqRange        <= decRange;
      resonatorDriveSel   <= decResDrv;
      doublerEnable       <= decDbl;
    end
  end

  // unbonded pads pulled up from reset onward
  assign padPullupForce = 1'b1;

endmodule

// *** optcfg_props.sv ***
// concurrent property checker for the configuration byte decoder
`timescale 1ns/1ps
module optcfg_props
  import optcfg_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYCLES_DEF
)(
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic        clkEn,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  input wire logic        userMemErase,
  input wire logic        padPullupForce,
  input wire logic        wdogHaltResetSel,
  input wire logic        wdogHwAlways,
  input wire logic        lowSupplyDetectorEn,
  input wire logic        auxSupplyDetectorEn,
  input wire logic [1:0]  voltThreshold,
  input wire logic        readoutProtect,
  input wire logic        package64,
  input wire logic [12:0] resetCycles,
  input wire logic [1:0]  oscKindSel,
  input wire logic [2:0]  oscFreqRange,
  input wire logic        resonatorDriveSel,
  input wire logic        doublerEnable
);
  logic [3:0]  relCnt_reg;
  logic [15:0] eraseCnt_reg;
  logic        mapped;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  assign mapped = wb_adr_i inside {OFS_CTRL, OFS_STATUS, OFS_BYTE0, OFS_BYTE1, OFS_DECODE};
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) relCnt_reg <= 4'h0;
    else if (relCnt_reg != 4'hf) relCnt_reg <= relCnt_reg + 4'h1;
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) eraseCnt_reg <= 16'h0000;
    else if (!userMemErase) eraseCnt_reg <= 16'h0000;
    else if (clkEn) eraseCnt_reg <= eraseCnt_reg + 16'h0001;
  end
  sequence s_taken;
    clkEn && wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence s_answer;
    (wb_ack_o || wb_err_o) && clkEn;
  endsequence
  property p_ack_map;
    s_taken ##0 mapped |=> wb_ack_o && !wb_err_o;
  endproperty
  property p_err_unmap;
    s_taken ##0 !mapped |=> wb_err_o && !wb_ack_o;
  endproperty
  property p_answer_once;
    s_answer |=> !(wb_ack_o || wb_err_o);
  endproperty
  property p_pullup;
    padPullupForce;
  endproperty
  property p_detect;
    lowSupplyDetectorEn == (voltThreshold != VD_OFF) && auxSupplyDetectorEn == lowSupplyDetectorEn;
  endproperty
  property p_rst_len;
    resetCycles == RST_CYC_LONG || resetCycles == RST_CYC_SHORT;
  endproperty
  property p_drive;
    resonatorDriveSel == (oscKindSel == OSC_RESONATOR);
  endproperty
  property p_hold;
    relCnt_reg == 4'hf |-> $stable({wdogHaltResetSel, wdogHwAlways, lowSupplyDetectorEn,
      auxSupplyDetectorEn, voltThreshold, readoutProtect, package64, resetCycles, oscKindSel,
      oscFreqRange, resonatorDriveSel, doublerEnable});
  endproperty
  property p_erase_len;
    $fell(userMemErase) |-> eraseCnt_reg == ERASE_CYCLES;
  endproperty
  a_ack_map: assert property (p_ack_map) else $error("mapped access not acked");
  a_err_unmap: assert property (p_err_unmap) else $error("unmapped access not refused");
  a_answer_once: assert property (p_answer_once) else $error("answer longer than one cycle");
  a_pullup: assert property (p_pullup) else $error("pad pull-up not forced");
  a_detect: assert property (p_detect) else $error("detector enable wrong");
  a_rst_len: assert property (p_rst_len) else $error("reset length illegal");
  a_drive: assert property (p_drive) else $error("resonator drive select wrong");
  a_hold: assert property (p_hold) else $error("decoded settings changed");
  a_erase_len: assert property (p_erase_len) else $error("user erase length wrong");
endmodule
bind option_byte_config_decoder optcfg_props #(.ERASE_CYCLES(ERASE_CYCLES)) props (
  .clk_sys(clk_sys), .arst_n(arst_n), .clkEn(clkEn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .userMemErase(userMemErase), .padPullupForce(padPullupForce),
  .wdogHaltResetSel(wdogHaltResetSel), .wdogHwAlways(wdogHwAlways),
  .lowSupplyDetectorEn(lowSupplyDetectorEn), .auxSupplyDetectorEn(auxSupplyDetectorEn),
  .voltThreshold(voltThreshold), .readoutProtect(readoutProtect), .package64(package64),
  .resetCycles(resetCycles), .oscKindSel(oscKindSel), .oscFreqRange(oscFreqRange),
  .resonatorDriveSel(resonatorDriveSel), .doublerEnable(doublerEnable));

// *** prog_tool.sv ***
// programming tool model: mode pin and bus master
`timescale 1ns/1ps
module prog_tool
  import optcfg_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        ack,
  input  wire logic        err,
  input  wire logic [31:0] datR,
  output logic             progModePin,
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [7:0]       adr,
  output logic [3:0]       sel,
  output logic [31:0]      datW
);
  initial begin
    progModePin = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    datW = 32'h0;
  end
  function automatic logic [7:0] legal0(input logic [7:0] b);
    logic [7:0] r;
    r = b | 8'h24;
    if (!r[B0_PROTECT]) r[B0_VD_HI:B0_VD_LO] = VD_OFF;
    return r;
  endfunction
  function automatic logic [7:0] legal1(input logic [7:0] b);
    logic [7:0] r;
    r = b;
    if (r[B1_OSC_HI:B1_OSC_LO] == OSC_RESONATOR) r[B1_RST_LEN] = 1'b0;
    if (r[B1_OSC_HI:B1_OSC_LO] == OSC_INT_RC || r[B1_RANGE_HI:B1_RANGE_LO] != 3'h1) begin
      r[B1_DOUBLER] = 1'b1;
    end
    return r;
  endfunction
  task automatic setMode(input logic v);
    @(posedge clk_sys);
    progModePin <= v;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    logic [31:0] v;
    v = d;
    if (w && a == OFS_BYTE0) v[7:0] = legal0(d[7:0]);
    if (w && a == OFS_BYTE1) v[7:0] = legal1(d[7:0]);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    datW <= v;
    do begin
      @(posedge clk_sys);
    end while (ack !== 1'b1 && err !== 1'b1);
    q = datR;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
endmodule

// *** tb_top.sv ***
// self-checking bench for the configuration byte decoder
`timescale 1ns/1ps
module tb_top;
  import optcfg_pkg::*;
  logic        clk_sys, arst_n, progModePin, cyc, stb, we, ack, err, memErase, clkEn;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] datW, datR, q;
  logic        e;
  int          err_total, check_count, cycles, eraseSeen;
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  prog_tool tool (.clk_sys(clk_sys), .ack(ack), .err(err), .datR(datR),
    .progModePin(progModePin), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .datW(datW));
  option_byte_config_decoder #(.ERASE_CYCLES(4)) dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .clkEn(clkEn), .maskCodedPin(1'b0), .progModePin(progModePin), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW),
    .wb_dat_o(datR), .wb_ack_o(ack), .wb_err_o(err), .userMemErase(memErase),
    .padPullupForce(), .wdogHaltResetSel(), .wdogHwAlways(), .lowSupplyDetectorEn(),
    .auxSupplyDetectorEn(), .voltThreshold(), .readoutProtect(), .package64(),
    .resetCycles(), .oscKindSel(), .oscFreqRange(), .resonatorDriveSel(), .doublerEnable());
  option_byte_config_decoder #(.ERASE_CYCLES(4), .MASK_BYTE0(8'h3d), .MASK_BYTE1(8'h82)) dut2 (
    .clk_sys(clk_sys), .arst_n(arst_n), .clkEn(clkEn), .maskCodedPin(1'b1),
    .progModePin(progModePin), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(), .wb_ack_o(), .wb_err_o(), .userMemErase(),
    .padPullupForce(), .wdogHaltResetSel(), .wdogHwAlways(), .lowSupplyDetectorEn(),
    .auxSupplyDetectorEn(), .voltThreshold(), .readoutProtect(), .package64(),
    .resetCycles(), .oscKindSel(), .oscFreqRange(), .resonatorDriveSel(), .doublerEnable());
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    check_count++;
    if (got !== ex) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic doReset();
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (10) @(posedge clk_sys);
  endtask
  task automatic decodeCheck();
    chk("halt", 2'b10, {dut.wdogHaltResetSel, dut2.wdogHaltResetSel});
    chk("hw", 2'b01, {dut.wdogHwAlways, dut2.wdogHwAlways});
    chk("detect", 4'h0, {dut.lowSupplyDetectorEn, dut.auxSupplyDetectorEn,
      dut2.lowSupplyDetectorEn, dut2.auxSupplyDetectorEn});
    chk("thr", 4'hf, {dut.voltThreshold, dut2.voltThreshold});
    chk("prot", 2'b01, {dut.readoutProtect, dut2.readoutProtect});
    chk("pkg", 2'b01, {dut.package64, dut2.package64});
    chk("rst", {RST_CYC_SHORT, RST_CYC_LONG}, {dut.resetCycles, dut2.resetCycles});
    chk("osc", {OSC_INT_RC, OSC_RESONATOR}, {dut.oscKindSel, dut2.oscKindSel});
    chk("range", 6'h39, {dut.oscFreqRange, dut2.oscFreqRange});
    chk("drv", 2'b01, {dut.resonatorDriveSel, dut2.resonatorDriveSel});
    chk("dbl", 2'b01, {dut.doublerEnable, dut2.doublerEnable});
    chk("pull", 2'b11, {dut.padPullupForce, dut2.padPullupForce});
  endtask
  task automatic eraseRun(input logic [31:0] expLen, input int hold);
    int k;
    eraseSeen = 0;
    tool.xfer(1'b1, OFS_CTRL, 32'h1, q, e);
    if (hold > 0) begin
      clkEn <= 1'b0;
      repeat (hold) @(posedge clk_sys);
      clkEn <= 1'b1;
    end
    for (k = 0; k < 20; k++) begin
      tool.xfer(1'b0, OFS_STATUS, 32'h0, q, e);
      if (q[0] === 1'b0) break;
    end
    chk("erase_len", expLen, eraseSeen);
    tool.xfer(1'b0, OFS_BYTE1, 32'h0, q, e);
    chk("byte1_erased", {24'h0, ERASED_BYTE}, q);
  endtask
  always @(posedge clk_sys) begin
    if (memErase === 1'b1) eraseSeen <= eraseSeen + 1;
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    arst_n = 1'b0;
    clkEn = 1'b1;
    cycles = 0;
    doReset();
    decodeCheck();
    $display("test decode done");
    tool.xfer(1'b0, OFS_BYTE0, 32'h0, q, e);
    chk("closed_read", 32'h0, q);
    tool.xfer(1'b1, OFS_BYTE0, 32'h3e, q, e);
    tool.xfer(1'b0, 8'h20, 32'h0, q, e);
    chk("unmapped", 1'b1, e);
    $display("test closed done");
    tool.setMode(1'b1);
    tool.xfer(1'b0, OFS_STATUS, 32'h0, q, e);
    chk("status", 5'h10, q[4:0]);
    tool.xfer(1'b0, OFS_DECODE, 32'h0, q, e);
    chk("decode_reg", 32'h0000f071, q);
    tool.xfer(1'b0, OFS_BYTE0, 32'h0, q, e);
    chk("byte0_blank", {24'h0, BLANK_BYTE0}, q);
    tool.xfer(1'b0, OFS_BYTE1, 32'h0, q, e);
    chk("byte1_blank", {24'h0, BLANK_BYTE1}, q);
    tool.xfer(1'b1, OFS_BYTE0, 32'h3e, q, e);
    tool.xfer(1'b0, OFS_BYTE0, 32'h0, q, e);
    chk("byte0_prog", 32'h3e, q);
    chk("prot_held", 1'b0, dut.readoutProtect);
    eraseRun(32'd8, 4);
    eraseRun(32'd0, 0);
    $display("test program done");
    doReset();
    decodeCheck();
    tool.xfer(1'b0, OFS_BYTE1, 32'h0, q, e);
    chk("byte1_reset", {24'h0, BLANK_BYTE1}, q);
    $display("test rereset done");
    finish_test();
  end
endmodule
